// ---- verilog/spc_pkg.sv ----
// Package for the speech command port: shared constants and types.
// Assumes a single 25 MHz clock (mclk) on both ends.
package spc_pkg;
  // ==========================================================
  // Widths
  localparam int IDX_W  = 8;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ        = 25;
  localparam int ROM_VALID_NS   = 2000;
  localparam int ROM_WAIT_CYC   = (ROM_VALID_NS * CLK_MHZ + 999) / 1000;
  localparam int SPEECH_MAX_US  = 410;
  localparam int SPEECH_MAX_CYC = SPEECH_MAX_US * CLK_MHZ;
  localparam int DEBOUNCE_CYC   = 16;
  localparam int SAMPLE_DIV     = 25;
  localparam int STRB_WIDTH_NS  = 430;
  localparam int STRB_CYC       = (STRB_WIDTH_NS * CLK_MHZ + 999) / 1000 + DEBOUNCE_CYC;
  // ==========================================================
  // Command kinds and data codes
  localparam logic CMD_START = 1'b0;
  localparam logic CMD_CLEAR = 1'b1;
  localparam logic [7:0] TAG_END     = 8'hff;
  localparam logic [7:0] TAG_SILENCE = 8'hfe;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 14'h0000;
  typedef enum logic [2:0] {
    SPC_IDLE, SPC_PWR, SPC_PTR_LO, SPC_PTR_HI, SPC_PARAM, SPC_WAVE, SPC_SILENCE
  } spc_state_t;
endpackage

// ---- verilog/spc_link_if.sv ----
// Interface joining the host end and the speech processor end, plus ROM.
// Assumes both ends run on the same mclk.
`timescale 1ns/1ps
`default_nettype none
interface spc_link_if;
  logic                      port_sel_n;
  logic                      wr_n;
  logic                      command_kind_select;
  logic [spc_pkg::IDX_W-1:0] expression_index_bus;
  logic                      sequence_done_flag;
  logic [spc_pkg::ADDR_W-1:0] rom_addr;
  logic [spc_pkg::DATA_W-1:0] rom_data;
  logic                      rom_power_enable;
  modport device (
    input  port_sel_n, wr_n, command_kind_select, expression_index_bus, rom_data,
    output sequence_done_flag, rom_addr, rom_power_enable
  );
  modport host (
    output port_sel_n, wr_n, command_kind_select, expression_index_bus,
    input  sequence_done_flag
  );
endinterface
`default_nettype wire

// ---- verilog/spc_device.sv ----
// Speech processor command front end and ROM fetch sequencer.
// Assumes host pins are asynchronous and ROM data is combinational on rom_addr.
`timescale 1ns/1ps
`default_nettype none
module spc_device (
  input  wire logic                       mclk,
  input  wire logic                       srst,
  spc_link_if.device                      link,
  output logic                            speech_valid,
  output logic [spc_pkg::DATA_W-1:0]      speech_sample,
  output logic [spc_pkg::DATA_W-1:0]      speech_param,
  output logic                            busy
);
  // ==========================================================
  // Pin synchronisers
  logic       sel_n_m_r, sel_n_s_r, wr_n_m_r, wr_n_s_r, kind_m_r, kind_s_r;
  logic [7:0] idx_m_r, idx_s_r;
  always_ff @(posedge mclk) begin
    sel_n_m_r <= link.port_sel_n;
    sel_n_s_r <= sel_n_m_r;
    wr_n_m_r  <= link.wr_n;
    wr_n_s_r  <= wr_n_m_r;
    kind_m_r  <= link.command_kind_select;
    kind_s_r  <= kind_m_r;
    idx_m_r   <= link.expression_index_bus;
    idx_s_r   <= idx_m_r;
  end
  // ==========================================================
  // Debounce of write strobe
  // A new level must hold for DEBOUNCE_CYC clocks before it is taken, so
  // switch bounce and short glitches never trigger a command; capture below still follows the synchronised strobe
  logic       wr_db_r;
  logic [4:0] db_cnt_r;
  wire        wr_differs = (wr_n_s_r != wr_db_r);
  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_db_r  <= 1'b1;
      db_cnt_r <= 5'h00;
    end else if (!wr_differs) begin
      db_cnt_r <= 5'h00;
    end else if (db_cnt_r == 5'(spc_pkg::DEBOUNCE_CYC - 1)) begin
      wr_db_r  <= wr_n_s_r;
      db_cnt_r <= 5'h00;
    end else begin
      db_cnt_r <= db_cnt_r + 5'h01;
    end
  end
  // ==========================================================
  // Command capture
  // Select, kind and index follow the pins only while the synchronised
  // strobe is low, so they freeze at its release; the host may drop select
  // right after the strobe, long before the debounced edge arrives
  logic       sel_seen_r, kind_held_r;
  logic [7:0] idx_hold_r;
  wire        wr_low  = !wr_n_s_r;
  wire        wr_rise = wr_db_r == 1'b0 && wr_differs &&
                        db_cnt_r == 5'(spc_pkg::DEBOUNCE_CYC - 1);
  wire        cmd_go  = wr_rise && sel_seen_r;
  wire        start   = cmd_go && kind_held_r == spc_pkg::CMD_START;
  always_ff @(posedge mclk) begin
    if (srst) begin
      sel_seen_r  <= 1'b0;
      kind_held_r <= 1'b1;
      idx_hold_r  <= 8'h00;
    end else if (wr_low) begin
      sel_seen_r  <= !sel_n_s_r;
      kind_held_r <= kind_s_r;
      if (!sel_n_s_r)
        idx_hold_r <= idx_s_r;
    end
  end
  // ==========================================================
  // Fetch sequencer
  // ROM layout: two pointer bytes at twice the index, then records of a
  // length byte and samples, a silence tag and count, or the end tag
  spc_pkg::spc_state_t st_r, st_nxt;
  logic [13:0] addr_r;
  logic [7:0]  ptr_lo_r, len_r;
  logic [6:0]  wait_r;
  logic [15:0] sil_r;
  logic        done_r, pwr_r, sil_arm_r;
  wire [7:0] d = link.rom_data;
  wire wait_done = wait_r == 7'(spc_pkg::ROM_WAIT_CYC);
  logic [4:0] div_r;
  wire tick = div_r == 5'(spc_pkg::SAMPLE_DIV - 1);
  wire is_end    = d == spc_pkg::TAG_END;
  wire is_sil    = d == spc_pkg::TAG_SILENCE;
  wire wave_last = tick && len_r == 8'h00;
  wire sil_last  = tick && !sil_arm_r && sil_r == 16'h0000;
  wire seq_end   = st_r == spc_pkg::SPC_PARAM && is_end && !start;
  // Step to the next ROM byte; the address wraps at the top of the space
  function automatic logic [13:0] step_addr(input logic [13:0] a);
    return a + 14'h0001;
  endfunction
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      spc_pkg::SPC_IDLE:    st_nxt = st_r;
      spc_pkg::SPC_PWR:     if (wait_done) st_nxt = spc_pkg::SPC_PTR_LO;
      spc_pkg::SPC_PTR_LO:  st_nxt = spc_pkg::SPC_PTR_HI;
      spc_pkg::SPC_PTR_HI:  st_nxt = spc_pkg::SPC_PARAM;
      spc_pkg::SPC_PARAM:   if (is_end) st_nxt = spc_pkg::SPC_IDLE;
                            else if (is_sil) st_nxt = spc_pkg::SPC_SILENCE;
                            else st_nxt = spc_pkg::SPC_WAVE;
      spc_pkg::SPC_WAVE:    if (wave_last) st_nxt = spc_pkg::SPC_PARAM;
      spc_pkg::SPC_SILENCE: if (sil_last) st_nxt = spc_pkg::SPC_PARAM;
    endcase
    if (start)
      st_nxt = spc_pkg::SPC_PWR;
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r <= spc_pkg::SPC_IDLE;
      addr_r <= spc_pkg::RESET_ADDR;
      ptr_lo_r <= 8'h00;
      len_r <= 8'h00;
      sil_r <= 16'h0000;
      wait_r <= 7'h00;
      div_r <= 5'h00;
      sil_arm_r <= 1'b0;
      pwr_r <= 1'b0;
      speech_valid <= 1'b0;
      speech_sample <= 8'h00;
      speech_param <= 8'h00;
    end else begin
      st_r <= st_nxt;
      div_r <= tick ? 5'h00 : div_r + 5'h01;
      speech_valid <= 1'b0;
      if (start) begin
        addr_r <= {5'h00, idx_hold_r, 1'b0};
        wait_r <= 7'h00;
        pwr_r  <= 1'b1;
        sil_arm_r <= 1'b0;
      end else begin
        unique case (st_r)
          spc_pkg::SPC_IDLE: pwr_r <= 1'b0;
          spc_pkg::SPC_PWR: if (!wait_done) wait_r <= wait_r + 7'h01;
          spc_pkg::SPC_PTR_LO: begin
            ptr_lo_r <= d;
            addr_r   <= step_addr(addr_r);
          end
          spc_pkg::SPC_PTR_HI: addr_r <= {d[5:0], ptr_lo_r};
          spc_pkg::SPC_PARAM: begin
            speech_param <= d;
            len_r <= d;
            sil_arm_r <= is_sil;
            addr_r <= step_addr(addr_r);
          end
          spc_pkg::SPC_WAVE: if (tick) begin
            speech_sample <= d;
            speech_valid  <= 1'b1;
            len_r  <= len_r - 8'h01;
            addr_r <= step_addr(addr_r);
          end
          spc_pkg::SPC_SILENCE: if (sil_arm_r) begin
            sil_r     <= {d, 8'hff};
            sil_arm_r <= 1'b0;
            addr_r    <= step_addr(addr_r);
          end else if (tick) begin
            speech_sample <= 8'h80;
            speech_valid  <= 1'b1;
            sil_r <= sil_r - 16'h0001;
          end
        endcase
      end
    end
  end
  // ==========================================================
  // Completion flag: an end in the same cycle as a clear-only command
  // still leaves the flag set, so the host never misses a completion
  always_ff @(posedge mclk) begin
    if (srst)
      done_r <= 1'b0;
    else if (seq_end)
      done_r <= 1'b1;
    else if (cmd_go)
      done_r <= 1'b0;
  end
  // ==========================================================
  // Link outputs
  // Playback runs regardless of select after the command
  assign busy = st_r != spc_pkg::SPC_IDLE;
  assign link.sequence_done_flag = done_r;
  assign link.rom_addr = addr_r;
  assign link.rom_power_enable = pwr_r;
endmodule // spc_device
`default_nettype wire

// ---- verilog/spc_host.sv ----
// Host end: issues start or clear commands over the strobed port.
// Assumes the device end samples the port through synchronisers.
`timescale 1ns/1ps
`default_nettype none
module spc_host (
  input  wire logic                       mclk,
  input  wire logic                       srst,
  spc_link_if.host                        link,
  input  wire logic                       cmd_valid,
  input  wire logic                       cmd_kind,
  input  wire logic [spc_pkg::IDX_W-1:0]  cmd_index,
  output logic                            cmd_ready,
  output logic                            done
);
  // ==========================================================
  // Strobe generator
  logic [5:0] cnt_r;
  logic       act_r, kind_r;
  logic [7:0] idx_r;
  logic       d_m_r, d_s_r;
  always_ff @(posedge mclk) begin
    d_m_r <= link.sequence_done_flag;
    d_s_r <= d_m_r;
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      act_r <= 1'b0;
      cnt_r <= 6'h00;
      kind_r <= 1'b1;
      idx_r <= 8'h00;
    end else if (!act_r) begin
      if (cmd_valid) begin
        act_r <= 1'b1;
        cnt_r <= 6'h00;
        kind_r <= cmd_kind;
        idx_r <= cmd_index;
      end
    end else if (cnt_r == 6'(2 * spc_pkg::STRB_CYC)) begin
      act_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 6'h01;
    end
  end
  // Select only around the write; strobe low in the middle
  assign link.port_sel_n = !act_r;
  assign link.wr_n = !(act_r && cnt_r > 6'h0f && cnt_r < 6'(spc_pkg::STRB_CYC + 16));
  assign link.command_kind_select = kind_r;
  assign link.expression_index_bus = idx_r;
  assign cmd_ready = !act_r;
  assign done = d_s_r;
endmodule // spc_host
`default_nettype wire

// ---- tb/spc_link_sva.sv ----
// Checker for the command link between the host end and the device end.
// Assumes one mclk domain; link signals come in as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module spc_link_sva (
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        port_sel_n,
  input wire logic        wr_n,
  input wire logic        command_kind_select,
  input wire logic [7:0]  expression_index_bus,
  input wire logic        sequence_done_flag,
  input wire logic [13:0] rom_addr,
  input wire logic [7:0]  rom_data,
  input wire logic        rom_power_enable
);
  // ==========================================================
  // Cycles since strobe release and since select was low
  logic [5:0] wr_hi_r;
  logic [5:0] sel_lo_r;
  logic [7:0] idx_r;
  logic       kind_r;
  wire  [5:0] wr_hi_nxt  = wr_n ? wr_hi_r + {5'h00, wr_hi_r != 6'h3f} : 6'h00;
  wire  [5:0] sel_lo_nxt = port_sel_n ? sel_lo_r + {5'h00, sel_lo_r != 6'h3f} : 6'h00;
  wire        strobe_lo  = !wr_n && !port_sel_n;
  always_ff @(posedge mclk) begin
    wr_hi_r  <= srst ? 6'h3f : wr_hi_nxt;
    sel_lo_r <= srst ? 6'h3f : sel_lo_nxt;
    idx_r    <= strobe_lo ? expression_index_bus : idx_r;
    kind_r   <= strobe_lo ? command_kind_select : kind_r;
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence strobe_settled_s;
    wr_hi_r >= 6'h0e && wr_hi_r <= 6'h1a;
  endsequence
  AST_DONE_FALL: assert property ($fell(sequence_done_flag) && !$past(srst) |-> strobe_settled_s)
    else $error("done cleared without a settled strobe");
  AST_SEL_GATE: assert property ($fell(sequence_done_flag) && !$past(srst) |-> sel_lo_r <= 6'h28)
    else $error("done cleared without select");
  AST_PWR_STROBE: assert property ($rose(rom_power_enable) |-> strobe_settled_s)
    else $error("start not on strobe release");
  AST_PWR_CLEAR: assert property ($rose(rom_power_enable) |-> !sequence_done_flag && !kind_r)
    else $error("start with done set or clear kind");
  AST_DONE_END: assert property ($rose(sequence_done_flag) |-> $past(rom_data) == 8'hff)
    else $error("done without end code");
  AST_DONE_PWR: assert property ($rose(sequence_done_flag) |-> $past(rom_power_enable))
    else $error("done while rom off");
  AST_DONE_HOLD: assert property (sequence_done_flag && wr_hi_r > 6'h1e |=> sequence_done_flag)
    else $error("done dropped without command");
  AST_ADDR_START: assert property ($rose(rom_power_enable) |-> ##[0:80] rom_addr == {5'h00, idx_r, 1'b0})
    else $error("first fetch not at index");
endmodule // spc_link_sva
`default_nettype wire

// ---- tb/spc_tb_top.sv ----
// Bench: host end drives the device end across the link.
// Assumes the speech ROM is a bench array read combinationally.
`timescale 1ns/1ps
`default_nettype none
module spc_tb_top;
  logic       mclk = 1'b0;
  logic       srst, cmd_valid, cmd_kind, cmd_ready, done, speech_valid, busy;
  logic [7:0] cmd_index, speech_sample, speech_param;
  logic [7:0] rom [0:16383];
  logic [7:0] got [$];
  int         error_cnt = 0;
  int         compares = 0;
  int         cyc = 0;
  int         n;
  spc_link_if spc_link_if_i ();
  assign spc_link_if_i.rom_data = rom[spc_link_if_i.rom_addr];
  spc_host spc_host_i (.mclk(mclk), .srst(srst), .link(spc_link_if_i), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_index(cmd_index), .cmd_ready(cmd_ready), .done(done));
  spc_device spc_device_i (.mclk(mclk), .srst(srst), .link(spc_link_if_i), .busy(busy),
    .speech_valid(speech_valid), .speech_sample(speech_sample), .speech_param(speech_param));
  spc_link_sva spc_link_sva_i (.mclk(mclk), .srst(srst), .port_sel_n(spc_link_if_i.port_sel_n),
    .wr_n(spc_link_if_i.wr_n), .command_kind_select(spc_link_if_i.command_kind_select),
    .expression_index_bus(spc_link_if_i.expression_index_bus),
    .sequence_done_flag(spc_link_if_i.sequence_done_flag), .rom_addr(spc_link_if_i.rom_addr),
    .rom_data(spc_link_if_i.rom_data), .rom_power_enable(spc_link_if_i.rom_power_enable));
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (speech_valid === 1'b1) got.push_back(speech_sample);
    if (cyc == 40000) begin
      error_cnt++;
      stop_test();
    end
  end
  // ==========================================================
  // Tasks
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmd(input logic k, input logic [7:0] idx);
    for (int i = 0; i < 300 && cmd_ready !== 1'b1; i++) @(negedge mclk);
    if (cmd_ready !== 1'b1) begin
      error_cnt++;
      $display("ERROR t=%0t ready=%h exp=%h", $time, cmd_ready, 1'b1);
    end
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_index = idx;
    @(negedge mclk);
    cmd_valid = 1'b0;
  endtask
  task automatic wait_flag(input logic v);
    for (n = 0; n < 20000 && spc_link_if_i.sequence_done_flag !== v; n++) @(negedge mclk);
    if (spc_link_if_i.sequence_done_flag !== v) begin
      error_cnt++;
      $display("ERROR t=%0t flag=%h exp=%h", $time, spc_link_if_i.sequence_done_flag, v);
    end
  endtask
  task automatic put(input logic [13:0] a, input logic [7:0] b0, input logic [7:0] b1);
    rom[a] = b0;
    rom[a + 14'h0001] = b1;
  endtask
  task automatic stop_test;
    $display("Compares %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    for (int a = 0; a < 16384; a++) rom[a] = 8'hff;
    put(14'h0006, 8'h00, 8'h01);
    put(14'h0100, 8'h01, 8'ha5);
    put(14'h0102, 8'h5a, 8'hff);
    put(14'h01fe, 8'hfc, 8'h3f);
    put(14'h3ffc, 8'h00, 8'h77);
    put(14'h000a, 8'h00, 8'h02);
    put(14'h0200, 8'hfe, 8'h00);
    put(14'h0202, 8'h00, 8'h33);
    srst = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind = 1'b0;
    cmd_index = 8'h00;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    repeat (20) @(negedge mclk);
    cmd(spc_pkg::CMD_START, 8'h03);
    wait_flag(1'b1);
    repeat (2) @(negedge mclk);
    check(8'(got.size()), 8'h02);
    check(got[0], 8'ha5);
    check(got[1], 8'h5a);
    check({7'h00, done}, 8'h01);
    got.delete();
    cmd(spc_pkg::CMD_CLEAR, 8'h03);
    wait_flag(1'b0);
    check({7'h00, spc_link_if_i.sequence_done_flag}, 8'h00);
    repeat (200) @(negedge mclk);
    check(8'(got.size()), 8'h00);
    cmd(spc_pkg::CMD_START, 8'hff);
    wait_flag(1'b1);
    check(got[0], 8'h77);
    cmd(spc_pkg::CMD_START, 8'h05);
    wait_flag(1'b0);
    repeat (300) @(negedge mclk);
    check({7'h00, busy}, 8'h01);
    check(speech_param, spc_pkg::TAG_SILENCE);
    cmd(spc_pkg::CMD_START, 8'h03);
    wait_flag(1'b1);
    check(got[$], 8'h5a);
    n = 0;
    foreach (got[i]) n += int'(got[i] === 8'h33);
    check(8'(n), 8'h00);
    cmd(spc_pkg::CMD_START, 8'h05);
    wait_flag(1'b0);
    wait_flag(1'b1);
    check(got[$], 8'h33);
    check(got[$-1], 8'h80);
    check({7'h00, n > 255 * spc_pkg::SAMPLE_DIV}, 8'h01);
    stop_test();
  end
endmodule // spc_tb_top
`default_nettype wire
